// *** src/reset_state_initializer.sv ***
// reset-state initialiser: picks reset cause, updates status flags, forces cpu state
`include "reset_init_cfg.svh"
module reset_state_initializer
    import reset_init_pkg::*;
#(
    parameter int PORT_BITS  = 8,
    parameter int TIMERS     = 4,
    parameter int SP_BITS    = 4,
    parameter int HOLD_CYC   = `RI_STRETCH_CYC
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 ARST_N,
    input  wire logic                 POR_REQ,
    input  wire logic                 LVR_REQ,
    input  wire logic                 WDT_REQ,
    input  wire logic                 LOW_POWER_MODE,
    input  wire logic                 SLEEP_ENTRY,
    input  wire logic                 WDT_CLEAR_INSTR,
    output logic                      CPU_RESET,
    output logic                      WATCHDOG_TIMEOUT_FLAG,
    output logic                      POWER_DOWN_FLAG,
    output logic                      PC_CLEAR,
    output logic                      SP_CLEAR,
    output logic [SP_BITS-1:0]        SP_VALUE,
    output logic                      PROGRAM_COUNTER_LOW_BYTE_CLEAR,
    output logic                      MEMORY_POINTER_CLEAR,
    output logic                      INT_DISABLE_ALL,
    output logic                      WDT_TB_CLEAR,
    output logic                      WDT_RUN,
    output logic [TIMERS-1:0]         TIMER_ENABLE_FORCE_OFF,
    output logic [PORT_BITS-1:0]      PORT_DIR_INPUT,
    output logic                      PERIPH_DEFAULTS_LOAD,
    output logic [2:0]                RESET_CAUSE
);
    // refuse widths the force vectors cannot carry
    if (PORT_BITS < 1 || TIMERS < 1 || SP_BITS < 1) begin : g_bad_width
        $error("reset_state_initializer: bad width");
    end

    // every piece of state in one struct
    typedef struct packed {
        logic [2:0]           req_m;   // first sync stage of por, lvr, wdt
        logic [2:0]           req_s;   // second sync stage
        logic [2:0]           req_p;   // previous synced level, for edges
        logic [1:0]           lpm_m;   // low power mode sync
        logic [1:0]           lpm_s;
        state_t               st;
        cause_t               cause;
        logic                 to_flag;
        logic                 pd_flag;
        logic                 cpu_rst;
        logic                 pc_clr;
        logic                 sp_clr;
        logic [SP_BITS-1:0]   sp_val;
        logic                 pcl_clr;
        logic                 mp_clr;
        logic                 int_dis;
        logic                 wdt_clr;
        logic                 wdt_run;
        logic [TIMERS-1:0]    tmr_off;
        logic [PORT_BITS-1:0] port_in;
        logic                 periph_ld;
    } st_t;

    st_t  s_q;          // registered state
    st_t  s_d;          // next state
    logic hold_start;   // pulse starting the cpu hold
    logic hold_busy;    // cpu still held in reset

    // the reset hold runs off a small counter so the cpu sees a clean pulse
    reset_stretch #(
        .CYCLES (HOLD_CYC)
    ) u_stretch (
        .clk    (CLK_SYS),
        .arst_n (ARST_N),
        .start  (hold_start),
        .busy   (hold_busy)
    );

    // choose the strongest cause among new requests
    function automatic cause_t pick_cause(input logic [2:0] rise, input logic lpm);
        if (rise[0]) begin
            pick_cause = CAUSE_POR;
        end else if (rise[1]) begin
            pick_cause = CAUSE_LVR;
        end else if (rise[2]) begin
            pick_cause = lpm ? CAUSE_WDT_S : CAUSE_WDT_N;
        end else begin
            pick_cause = CAUSE_NONE;
        end
    endfunction : pick_cause

    logic [2:0] rise;   // rising edges of synced requests
    cause_t     c_new;  // cause seen this cycle

    // next-state logic
    always_comb begin
        s_d        = s_q;
        rise       = s_q.req_s & ~s_q.req_p;
        c_new      = pick_cause(rise, s_q.lpm_s[1]);
        hold_start = 1'b0;
        // detector requests come from analog blocks, so synchronise them
        s_d.req_m  = {WDT_REQ, LVR_REQ, POR_REQ};
        s_d.req_s  = s_q.req_m;
        s_d.req_p  = s_q.req_s;
        s_d.lpm_m  = {s_q.lpm_m[0], LOW_POWER_MODE};
        s_d.lpm_s  = {s_q.lpm_s[0], s_q.lpm_m[1]};
        // one-cycle strobes default low
        s_d.pc_clr    = 1'b0;
        s_d.sp_clr    = 1'b0;
        s_d.pcl_clr   = 1'b0;
        s_d.mp_clr    = 1'b0;
        s_d.wdt_clr   = 1'b0;
        s_d.periph_ld = 1'b0;
        // status flag updates by ordinary operation
        if (SLEEP_ENTRY) begin
            s_d.pd_flag = 1'b1;
            s_d.to_flag = 1'b0;
        end else if (WDT_CLEAR_INSTR) begin
            s_d.pd_flag = 1'b0;
            s_d.to_flag = 1'b0;
        end
        case (s_q.st)
            ST_IDLE: begin
                // a new cause starts apply; a flag change the same cycle still takes effect
                if (c_new != CAUSE_NONE) begin
                    s_d.cause = c_new;
                    s_d.st    = ST_APPLY;
                end
            end
            ST_APPLY: begin
                hold_start  = 1'b1;
                s_d.cpu_rst = 1'b1;
                s_d.pc_clr  = 1'b1;
                s_d.sp_clr  = 1'b1;
                s_d.pcl_clr = 1'b1;
                s_d.st      = ST_HOLD;
                case (s_q.cause)
                    CAUSE_POR: begin
                        s_d.to_flag   = 1'b0;
                        s_d.pd_flag   = 1'b0;
                        s_d.mp_clr    = 1'b1;
                        s_d.int_dis   = 1'b1;
                        s_d.wdt_clr   = 1'b1;
                        s_d.wdt_run   = 1'b1;
                        s_d.tmr_off   = '1;
                        s_d.port_in   = '1;
                        s_d.sp_val    = SP_BITS'(`RI_STACK_TOP_IDX);
                        s_d.periph_ld = 1'b1;
                    end
                    CAUSE_LVR, CAUSE_WDT_N: begin
                        // normal watchdog reset matches low voltage, plus timeout
                        s_d.to_flag   = (s_q.cause == CAUSE_WDT_N) ? 1'b1 : s_q.to_flag;
                        s_d.mp_clr    = 1'b1;
                        s_d.int_dis   = 1'b1;
                        s_d.wdt_run   = 1'b1;
                        s_d.tmr_off   = '1;
                        s_d.port_in   = '1;
                        s_d.sp_val    = SP_BITS'(`RI_STACK_TOP_IDX);
                        s_d.periph_ld = 1'b1;
                    end
                    CAUSE_WDT_S: begin
                        // pointers, ports, timers kept; only pc and sp restart
                        s_d.to_flag = 1'b1;
                        s_d.pd_flag = 1'b1;
                        s_d.sp_val  = SP_BITS'(`RI_STACK_TOP_IDX);
                    end
                    default: begin
                        s_d.st = ST_IDLE;
                    end
                endcase
            end
            ST_HOLD: begin
                // any new cause, stronger or not, restarts the sequence
                if (c_new != CAUSE_NONE) begin
                    s_d.cause = c_new;
                    s_d.st    = ST_APPLY;
                end else if (!hold_busy) begin
                    s_d.cpu_rst = 1'b0;
                    s_d.int_dis = 1'b0;
                    s_d.tmr_off = '0;
                    s_d.port_in = '0;
                    s_d.st      = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // state register; cold start behaves as a pending power-on
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q         <= '0;
            s_q.st      <= ST_APPLY;
            s_q.cause   <= CAUSE_POR;
            s_q.cpu_rst <= 1'b1;
            s_q.int_dis <= 1'b1;
            s_q.tmr_off <= '1;
            s_q.port_in <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    always_comb begin
        CPU_RESET                      = s_q.cpu_rst;
        WATCHDOG_TIMEOUT_FLAG          = s_q.to_flag;
        POWER_DOWN_FLAG                = s_q.pd_flag;
        PC_CLEAR                       = s_q.pc_clr;
        SP_CLEAR                       = s_q.sp_clr;
        SP_VALUE                       = s_q.sp_val;
        PROGRAM_COUNTER_LOW_BYTE_CLEAR = s_q.pcl_clr;
        MEMORY_POINTER_CLEAR           = s_q.mp_clr;
        INT_DISABLE_ALL                = s_q.int_dis;
        WDT_TB_CLEAR                   = s_q.wdt_clr;
        WDT_RUN                        = s_q.wdt_run;
        TIMER_ENABLE_FORCE_OFF         = s_q.tmr_off;
        PORT_DIR_INPUT                 = s_q.port_in;
        PERIPH_DEFAULTS_LOAD           = s_q.periph_ld;
        RESET_CAUSE                    = s_q.cause;
    end
endmodule : reset_state_initializer

// *** src/reset_init_cfg.svh ***
// timing counts and reset values of the reset-state initialiser
`ifndef RESET_INIT_CFG_SVH
`define RESET_INIT_CFG_SVH
`define RI_CLK_MHZ         125
`define RI_STRETCH_NS      40
`define RI_STRETCH_CYC     ((`RI_STRETCH_NS * `RI_CLK_MHZ + 999) / 1000)
`define RI_BYTE_CLEAR      8'h00
`define RI_INTC0_CLEAR     7'h00
`define RI_TIMER_OFF       4'h0
`define RI_PORT_INPUT      8'hff
`define RI_STACK_TOP_IDX   0
`endif

// *** src/reset_init_pkg.sv ***
// types shared by the reset-state initialiser
package reset_init_pkg;
    // reset cause chosen for a pending initialisation
    typedef enum logic [2:0] {
        CAUSE_NONE  = 3'h0,
        CAUSE_POR   = 3'h1,
        CAUSE_LVR   = 3'h3,
        CAUSE_WDT_N = 3'h2,
        CAUSE_WDT_S = 3'h6
    } cause_t;
    // sequencer states, gray along idle -> apply -> hold
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_APPLY = 2'h1,
        ST_HOLD  = 2'h3
    } state_t;
endpackage : reset_init_pkg

// *** src/reset_stretch.sv ***
// stretches one reset strobe into a counted hold pulse
module reset_stretch #(
    parameter int CYCLES = 5
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    output logic      busy
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       busy;
    } st_t;

    st_t s_q;  // registered state
    st_t s_d;  // next state

    // the counter is eight bits wide, so longer holds cannot be served
    if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
        $error("reset_stretch: CYCLES out of range");
    end

    // count down while busy, reload on start
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.cnt  = 8'(CYCLES);
            s_d.busy = 1'b1;
        end else if (s_q.cnt != 8'h00) begin
            s_d.cnt  = s_q.cnt - 8'h01;
            s_d.busy = (s_q.cnt != 8'h01);
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
endmodule : reset_stretch

// *** dv/reset_state_initializer_props.sv ***
// port checker of the reset-state initialiser
module reset_state_initializer_props #(
    parameter int SP_BITS   = 4,
    parameter int TIMERS    = 4,
    parameter int PORT_BITS = 8
) (
    input wire logic                 CLK_SYS,
    input wire logic                 ARST_N,
    input wire logic                 SLEEP_ENTRY,
    input wire logic                 WDT_CLEAR_INSTR,
    input wire logic                 CPU_RESET,
    input wire logic                 WATCHDOG_TIMEOUT_FLAG,
    input wire logic                 POWER_DOWN_FLAG,
    input wire logic                 PC_CLEAR,
    input wire logic                 SP_CLEAR,
    input wire logic [SP_BITS-1:0]   SP_VALUE,
    input wire logic                 PROGRAM_COUNTER_LOW_BYTE_CLEAR,
    input wire logic                 MEMORY_POINTER_CLEAR,
    input wire logic                 INT_DISABLE_ALL,
    input wire logic                 WDT_TB_CLEAR,
    input wire logic                 WDT_RUN,
    input wire logic [TIMERS-1:0]    TIMER_ENABLE_FORCE_OFF,
    input wire logic [PORT_BITS-1:0] PORT_DIR_INPUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // a sleep watchdog reset clears the counter but keeps the pointers
    sequence s_sleep_rst;
        PC_CLEAR && !MEMORY_POINTER_CLEAR;
    endsequence
    sequence s_both_set;
        ##[0:1] (WATCHDOG_TIMEOUT_FLAG && POWER_DOWN_FLAG);
    endsequence
    a_pulse_once: assert property (PC_CLEAR |=> !PC_CLEAR) else $error("pc clear longer than one cycle");
    a_clear_set: assert property (PC_CLEAR |-> SP_CLEAR && PROGRAM_COUNTER_LOW_BYTE_CLEAR) else $error("pc clear alone");
    a_pointer_pc: assert property (MEMORY_POINTER_CLEAR |-> PC_CLEAR) else $error("pointer clear without pc clear");
    a_sleep_flags: assert property (s_sleep_rst |-> s_both_set) else $error("sleep reset flags not both set");
    a_full_forces: assert property (MEMORY_POINTER_CLEAR |-> ##[0:1] (INT_DISABLE_ALL
        && (&TIMER_ENABLE_FORCE_OFF) && (&PORT_DIR_INPUT))) else $error("forced levels missing");
    a_force_hold: assert property (INT_DISABLE_ALL |-> CPU_RESET) else $error("interrupt disable outside reset");
    a_wdt_runs: assert property (WDT_TB_CLEAR |-> ##[0:1] WDT_RUN ##1 WDT_RUN[*8]) else $error("watchdog stopped");
    a_stack_top: assert property (SP_CLEAR |-> SP_VALUE == '0) else $error("stack pointer not at top");
    // a reset applied in the same cycle wins over the flag pulse; its clear strobe shows that
    a_sleep_entry: assert property (SLEEP_ENTRY && !CPU_RESET |=> PC_CLEAR ||
        (POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG)) else $error("sleep entry flags wrong");
    a_wdt_clear: assert property (WDT_CLEAR_INSTR && !SLEEP_ENTRY && !CPU_RESET |=> PC_CLEAR ||
        (!POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG)) else $error("watchdog clear flags wrong");
endmodule : reset_state_initializer_props

bind reset_state_initializer reset_state_initializer_props #(.SP_BITS(SP_BITS), .TIMERS(TIMERS), .PORT_BITS(PORT_BITS))
    props_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SLEEP_ENTRY(SLEEP_ENTRY), .WDT_CLEAR_INSTR(WDT_CLEAR_INSTR),
    .CPU_RESET(CPU_RESET), .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG), .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
    .PC_CLEAR(PC_CLEAR), .SP_CLEAR(SP_CLEAR), .SP_VALUE(SP_VALUE), .MEMORY_POINTER_CLEAR(MEMORY_POINTER_CLEAR),
    .PROGRAM_COUNTER_LOW_BYTE_CLEAR(PROGRAM_COUNTER_LOW_BYTE_CLEAR), .INT_DISABLE_ALL(INT_DISABLE_ALL),
    .WDT_TB_CLEAR(WDT_TB_CLEAR), .WDT_RUN(WDT_RUN), .TIMER_ENABLE_FORCE_OFF(TIMER_ENABLE_FORCE_OFF),
    .PORT_DIR_INPUT(PORT_DIR_INPUT));

// *** dv/tb_reset_state_initializer.sv ***
// self-checking bench of the reset-state initialiser
`include "reset_init_cfg.svh"
module tb_reset_state_initializer;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, arst_n, por, lvr, wdt, lpm, sleep, wclr;        // driven inputs
    logic       cpu_rst, to_f, pd_f, pc_c, sp_c, pcl_c, mp_c;        // observed outputs
    logic       int_d, tb_c, run, periph;
    logic [3:0] sp_v, tmr;
    logic [7:0] dir;
    logic [2:0] cause;
    int         failures, n_checks, cycles;

    reset_state_initializer reset_state_initializer_i (.CLK_SYS(clk), .ARST_N(arst_n), .POR_REQ(por),
        .LVR_REQ(lvr), .WDT_REQ(wdt), .LOW_POWER_MODE(lpm), .SLEEP_ENTRY(sleep), .WDT_CLEAR_INSTR(wclr),
        .CPU_RESET(cpu_rst), .WATCHDOG_TIMEOUT_FLAG(to_f), .POWER_DOWN_FLAG(pd_f), .PC_CLEAR(pc_c),
        .SP_CLEAR(sp_c), .SP_VALUE(sp_v), .PROGRAM_COUNTER_LOW_BYTE_CLEAR(pcl_c), .MEMORY_POINTER_CLEAR(mp_c),
        .INT_DISABLE_ALL(int_d), .WDT_TB_CLEAR(tb_c), .WDT_RUN(run), .TIMER_ENABLE_FORCE_OFF(tmr),
        .PORT_DIR_INPUT(dir), .PERIPH_DEFAULTS_LOAD(periph), .RESET_CAUSE(cause));

    // 125 mhz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the hundred and some cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            summarize();
        end
    end
    // inputs move one nanosecond after the edge so sampling never races
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one reset request: pulses, forced levels, then flags and cause once the hold is over
    task req(input logic [2:0] m, input logic [3:0] ep, input logic [3:0] ef, input logic [1:0] efl,
             input logic [2:0] ec);
        int i;
        {por, lvr, wdt} = m;
        for (i = 0; i < 20 && pc_c !== 1'b1; i++) step(1);
        chk({4'h0, pc_c, sp_c, pcl_c, mp_c}, {4'h0, ep}, "clear pulses");
        chk({6'h0, tb_c, periph}, {6'h0, ec == 3'h1, ep[0]}, "load pulses");
        chk({4'h0, sp_v}, 8'(`RI_STACK_TOP_IDX), "stack top");
        step(1);
        {por, lvr, wdt} = 3'h0;
        chk({4'h0, int_d, &tmr, &dir, run}, {4'h0, ef}, "forced levels");
        for (i = 0; i < 30 && cpu_rst !== 1'b0; i++) step(1);
        step(3);
        chk({6'h0, to_f, pd_f}, {6'h0, efl}, "status flags");
        chk({5'h0, cause}, {5'h0, ec}, "reset cause");
    endtask : req
    // sleep entry or watchdog clear instruction, one cycle each
    task fop(input logic s, input logic c, input logic [1:0] efl);
        sleep = s;
        wclr = c;
        step(1);
        sleep = 1'b0;
        wclr = 1'b0;
        step(1);
        chk({6'h0, to_f, pd_f}, {6'h0, efl}, "flag update");
    endtask : fop
    task t_power_on;
        chk({4'h0, cpu_rst, int_d, &tmr, &dir}, 8'h0f, "levels in reset");
        arst_n = 1'b1;
        req(3'h0, 4'hf, 4'hf, 2'b00, 3'h1);
        $display("test power_on done");
    endtask : t_power_on
    task t_wdt_normal;
        fop(1'b1, 1'b0, 2'b01);
        req(3'b001, 4'hf, 4'hf, 2'b11, 3'h2);
        fop(1'b0, 1'b1, 2'b00);
        req(3'b001, 4'hf, 4'hf, 2'b10, 3'h2);
        $display("test wdt_normal done");
    endtask : t_wdt_normal
    task t_lvr;
        req(3'b010, 4'hf, 4'hf, 2'b10, 3'h3);
        fop(1'b1, 1'b0, 2'b01);
        req(3'b010, 4'hf, 4'hf, 2'b01, 3'h3);
        $display("test lvr done");
    endtask : t_lvr
    task t_wdt_sleep;
        lpm = 1'b1;
        fop(1'b0, 1'b1, 2'b00);
        req(3'b001, 4'b1110, 4'b0001, 2'b11, 3'h6);
        lpm = 1'b0;
        step(3);
        $display("test wdt_sleep done");
    endtask : t_wdt_sleep
    task t_priority;
        req(3'b100, 4'hf, 4'hf, 2'b00, 3'h1);
        req(3'b101, 4'hf, 4'hf, 2'b00, 3'h1);
        fop(1'b1, 1'b0, 2'b01);
        req(3'b011, 4'hf, 4'hf, 2'b01, 3'h3);
        fop(1'b1, 1'b1, 2'b01);
        $display("test priority done");
    endtask : t_priority
    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // reset for six cycles, then the scenarios in turn
    initial begin
        {arst_n, por, lvr, wdt, lpm, sleep, wclr} = 7'h0;
        failures = 0;
        n_checks = 0;
        step(6);
        t_power_on();
        t_wdt_normal();
        t_lvr();
        t_wdt_sleep();
        t_priority();
        summarize();
    end
endmodule : tb_reset_state_initializer
